/* File: sdpe_pkg.sv */
// sdpe_pkg: shared constants and types for the speed/direction pulse encoder
// assumes a 100 MHz reference clock
package sdpe_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FWD_WIDTH_US = 45;
  localparam int unsigned REV_WIDTH_US = 90;
  localparam int unsigned ND_WIDTH_US = 180;
  localparam int unsigned FWD_CYCLES = FWD_WIDTH_US * CLK_MHZ;
  localparam int unsigned REV_CYCLES = REV_WIDTH_US * CLK_MHZ;
  localparam int unsigned ND_CYCLES = ND_WIDTH_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CAL_EDGES = 3;
  localparam int unsigned CAL_W = 4;
  localparam int unsigned POWER_ON_US = 40;
  localparam int unsigned POWER_ON_CYCLES = POWER_ON_US * CLK_MHZ;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SDPE_DIR_ND = 2'h0,
    SDPE_DIR_FWD = 2'h1,
    SDPE_DIR_REV = 2'h2
  } sdpe_dir_t;

  typedef struct packed
  {
    logic ch1;
    logic ch2;
  } sdpe_chan_t;

  typedef struct packed
  {
    logic edge_seen;
    logic rising;
    sdpe_dir_t dir;
  } sdpe_evt_t;

endpackage : sdpe_pkg

/* File: sdpe_dir_detect.sv */
// sdpe_dir_detect: channel hysteresis and direction classification
// assumes analog comparator levels arrive synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module sdpe_dir_detect
  import sdpe_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset
  input wire logic enable, // detection allowed
  input wire sdpe_chan_t above_op, // signal above operate_threshold
  input wire sdpe_chan_t below_rel, // signal below release_threshold
  input wire logic vibration, // vibration flag
  output var sdpe_evt_t evt // channel 1 switching event
);
  sdpe_chan_t state_q, state_d;
  logic [CAL_W-1:0] cal_q, cal_d;
  logic last_dir_q, last_dir_d;
  sdpe_evt_t evt_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  function automatic logic hyst(input logic cur, input logic op, input logic rel);
    hyst = cur ? ~rel : op;
  endfunction : hyst

  always_comb
  begin
    state_d = state_q;
    cal_d = cal_q;
    last_dir_d = last_dir_q;
    evt_d = '0;
    if (enable)
    begin
      state_d.ch1 = hyst(state_q.ch1, above_op.ch1, below_rel.ch1);
      state_d.ch2 = hyst(state_q.ch2, above_op.ch2, below_rel.ch2);
      if (state_d.ch1 != state_q.ch1)
      begin
        evt_d.edge_seen = 1'b1;
        evt_d.rising = state_d.ch1;
        // forward when ch2 already agrees with the new ch1 level (pin4 to pin1 travel)
        last_dir_d = (state_q.ch2 == state_d.ch1);
        // an empty count holds no direction yet, so the first edge cannot count as a change
        if (vibration || (cal_q != '0 && last_dir_d != last_dir_q))
          cal_d = '0;
        else if (cal_q != CAL_W'(CAL_EDGES))
          cal_d = cal_q + CAL_W'(1);
        if (cal_q != CAL_W'(CAL_EDGES) || vibration)
          evt_d.dir = SDPE_DIR_ND;
        else
          evt_d.dir = last_dir_d ? SDPE_DIR_FWD : SDPE_DIR_REV;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
      cal_q <= '0;
      last_dir_q <= 1'b0;
      evt <= '0;
    end
    else
    begin
      state_q <= state_d;
      cal_q <= cal_d;
      last_dir_q <= last_dir_d;
      evt <= evt_d;
    end
  end
endmodule : sdpe_dir_detect
`default_nettype wire

/* File: sdpe_top.sv */
// sdpe_top: output pulse encoder for a speed and direction tooth sensor
// assumes comparator inputs synchronous to REF_CLK
// Operation
// - one output pulse per passing tooth
// - direction carried only in pulse width
// - forward pulses are 45 us wide
// - reverse pulses are 90 us wide
// - unknown direction uses non-direction width
// - forward means pin4 toward pin1 travel
// - only channel 1 switching triggers pulses
// - pulse starts at the sensed edge
// - profile detection starts after power-on time
// - output idle until first switchpoint
// - direction widths only after calibration completes
// - channel hysteresis on operate/release thresholds
// - vibration pulses use non-direction width
`timescale 1ns/10ps
`default_nettype none
module sdpe_top
  import sdpe_pkg::*;
#(
  parameter int unsigned POWER_ON_CNT = POWER_ON_CYCLES
)
(
  input wire logic REF_CLK, // 100 MHz clock
  input wire logic RST_N, // async reset, active low
  input wire sdpe_chan_t ABOVE_OP, // above operate_threshold per channel
  input wire sdpe_chan_t BELOW_REL, // below release_threshold per channel
  input wire logic VIBRATION, // vibration detected
  output logic PULSE_OUT, // encoded output pulse, high active
  output logic READY // power-on time elapsed
);
  import sdpe_pkg::*;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n_int;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_int = rst_sync_q[1];

  // ****************************************************************
  // power-on timer
  // ****************************************************************
  logic [CNT_W-1:0] por_q, por_d;
  logic ready_q, ready_d;

  always_comb
  begin
    por_d = por_q;
    ready_d = ready_q;
    if (!ready_q)
    begin
      if (por_q == CNT_W'(POWER_ON_CNT - 1))
        ready_d = 1'b1;
      else
        por_d = por_q + CNT_W'(1);
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      por_q <= '0;
      ready_q <= 1'b0;
    end
    else
    begin
      por_q <= por_d;
      ready_q <= ready_d;
    end
  end

  // ****************************************************************
  // direction detection
  // ****************************************************************
  sdpe_evt_t evt;

  sdpe_dir_detect u_dir
  (
    .clk(REF_CLK),
    .rst_n(rst_n_int),
    .enable(ready_q),
    .above_op(ABOVE_OP),
    .below_rel(BELOW_REL),
    .vibration(VIBRATION),
    .evt(evt)
  );

  // ****************************************************************
  // pulse generator
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SDPE_IDLE = 2'b01,
    SDPE_HIGH = 2'b10
  } sdpe_pstate_t;

  sdpe_pstate_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  function automatic logic [CNT_W-1:0] width_of(input sdpe_dir_t d);
    unique case (d)
      SDPE_DIR_FWD: width_of = CNT_W'(FWD_CYCLES);
      SDPE_DIR_REV: width_of = CNT_W'(REV_CYCLES);
      default: width_of = CNT_W'(ND_CYCLES);
    endcase
  endfunction : width_of

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    out_d = out_q;
    // a switching edge restarts the pulse, merging it with any pulse still running
    if (evt.edge_seen)
    begin
      st_d = SDPE_HIGH;
      cnt_d = width_of(evt.dir) - CNT_W'(1);
      out_d = 1'b1;
    end
    else
    begin
      unique case (st_q)
        SDPE_IDLE:
        begin
          out_d = 1'b0;
        end
        SDPE_HIGH:
        begin
          if (cnt_q == '0)
          begin
            st_d = SDPE_IDLE;
            out_d = 1'b0;
          end
          else
            cnt_d = cnt_q - CNT_W'(1);
        end
        default:
        begin
          st_d = SDPE_IDLE;
          out_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      st_q <= SDPE_IDLE;
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign PULSE_OUT = out_q;
  assign READY = ready_q;
endmodule : sdpe_top
`default_nettype wire

/* File: sdpe_top_sva.sv */
// sdpe_top_sva: port checker for the pulse encoder
// assumes it is bound onto sdpe_top
`timescale 1ns/10ps
`default_nettype none
module sdpe_sva
  import sdpe_pkg::*;
#(
  parameter int unsigned POWER_ON_CNT = 10
)
(
  input wire logic REF_CLK, // clock
  input wire logic RST_N, // reset
  input wire sdpe_chan_t ABOVE_OP, // operate level
  input wire sdpe_chan_t BELOW_REL, // release level
  input wire logic VIBRATION, // vibration
  input wire logic PULSE_OUT, // output pulse
  input wire logic READY // power-on done
);
  logic s1_q;
  logic vib_q;
  logic [15:0] cnt_q;
  logic [15:0] rcnt_q;
  logic [2:0] ev_q;
  wire logic evt = READY && (s1_q ? BELOW_REL.ch1 : ABOVE_OP.ch1);
  wire logic w_fwd = (cnt_q - 16'(FWD_CYCLES)) inside {[1:3]};
  wire logic w_rev = (cnt_q - 16'(REV_CYCLES)) inside {[1:3]};
  wire logic w_nd = (cnt_q - 16'(ND_CYCLES)) inside {[1:3]};
  // channel 1 state, cycles since its last switch, events seen
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      s1_q <= 1'b0;
      vib_q <= 1'b0;
      cnt_q <= 16'h0000;
      rcnt_q <= 16'h0000;
      ev_q <= 3'h0;
    end
    else
    begin
      s1_q <= s1_q ^ evt;
      vib_q <= evt ? VIBRATION : vib_q;
      cnt_q <= evt ? 16'h0001 : cnt_q + 16'(cnt_q != 16'hffff);
      rcnt_q <= rcnt_q + 16'(!READY);
      ev_q <= ev_q + 3'(evt && ev_q != 3'h7);
    end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_fall;
    $fell(PULSE_OUT);
  endsequence
  a_reset_quiet: assert property ($rose(RST_N) |-> (!PULSE_OUT && !READY)[*2])
    else $error("output active after reset");
  a_pre_event_idle: assert property (ev_q == 3'h0 |-> !PULSE_OUT)
    else $error("pulse before first switchpoint");
  a_pulse_start: assert property (evt |-> ##[2:3] PULSE_OUT)
    else $error("no pulse after channel 1 switch");
  a_rise_cause: assert property ($rose(PULSE_OUT) |-> $past(evt, 2) || $past(evt, 3))
    else $error("pulse without channel 1 switch");
  a_width_legal: assert property (s_fall |-> w_fwd || w_rev || w_nd)
    else $error("illegal pulse width");
  a_cal_nd: assert property (s_fall ##0 ev_q <= 3'h3 |-> w_nd)
    else $error("direction width before calibration");
  a_vib_nd: assert property (s_fall ##0 vib_q |-> w_nd)
    else $error("direction width during vibration");
  a_ready_time: assert property ($rose(READY) |-> (rcnt_q - 16'(POWER_ON_CNT)) inside {[0:4]})
    else $error("power-on time wrong");
endmodule : sdpe_sva
bind sdpe_top sdpe_sva #(.POWER_ON_CNT(POWER_ON_CNT)) i_sdpe_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .ABOVE_OP(ABOVE_OP), .BELOW_REL(BELOW_REL), .VIBRATION(VIBRATION), .PULSE_OUT(PULSE_OUT), .READY(READY));
`default_nettype wire

/* File: sdpe_ctl.sv */
// sdpe_ctl: controller model that times each output pulse
// assumes pulse is synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module sdpe_ctl
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic pulse, // sensor output
  output logic [15:0] width, // last high width
  output logic [15:0] count // pulses seen
);
  logic [15:0] run_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      run_q <= 16'h0000;
      width <= 16'h0000;
      count <= 16'h0000;
    end
    else
    begin
      run_q <= pulse ? run_q + 16'h0001 : 16'h0000;
      if (!pulse && run_q != 16'h0000)
      begin
        width <= run_q;
        count <= count + 16'h0001;
      end
    end
endmodule : sdpe_ctl
`default_nettype wire

/* File: tb_top.sv */
// tb_top: self-checking bench for sdpe_top
// assumes sdpe_ctl and the bound checker are compiled
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sdpe_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vib = 1'b0;
  logic l1 = 1'b0;
  sdpe_chan_t up = '0;
  sdpe_chan_t dn = '0;
  logic pulse;
  logic ready;
  logic [15:0] width;
  logic [15:0] count;
  int fails = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  sdpe_top #(.POWER_ON_CNT(10)) i_sdpe_top (.REF_CLK(clk), .RST_N(rst_n), .ABOVE_OP(up),
    .BELOW_REL(dn), .VIBRATION(vib), .PULSE_OUT(pulse), .READY(ready));
  sdpe_ctl i_sdpe_ctl (.clk(clk), .rst_n(rst_n), .pulse(pulse), .width(width), .count(count));
  task chk(logic ok, string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk
  task drive(logic [1:0] u, logic [1:0] d);
    @(negedge clk);
    up = u;
    dn = d;
    @(negedge clk);
    up = '0;
    dn = '0;
  endtask : drive
  // ch2 is placed first, then ch1 switches
  task ev(logic fwd);
    logic n;
    logic c2;
    n = ~l1;
    c2 = fwd ? n : ~n;
    drive({1'b0, c2}, {1'b0, ~c2});
    drive({n, 1'b0}, {~n, 1'b0});
    l1 = n;
  endtask : ev
  task expw(logic [15:0] w);
    logic [15:0] c0;
    c0 = count;
    repeat (20000) if (count === c0) @(negedge clk);
    chk(count === c0 + 16'h0001 && width === w, "pulse width");
  endtask : expw
  task t_start;
    chk(ready === 1'b1 && pulse === 1'b0, "idle after power-on");
    // events 4 cycles apart restart the pulse, so it stays high 4 cycles longer per extra event
    repeat (3) ev(1'b1);
    expw(16'(ND_CYCLES) + 16'h0008);
    ev(1'b1);
    expw(16'(FWD_CYCLES));
    drive(2'b01, 2'b00);
    drive(2'b00, 2'b01);
    repeat (5) @(negedge clk);
    chk(pulse === 1'b0, "ch2 triggered");
    $display("t_start done");
  endtask : t_start
  task t_rev;
    repeat (4) ev(1'b0);
    expw(16'(ND_CYCLES) + 16'h000c);
    ev(1'b0);
    expw(16'(REV_CYCLES));
    $display("t_rev done");
  endtask : t_rev
  task t_vib;
    @(negedge clk);
    vib = 1'b1;
    ev(1'b0);
    expw(16'(ND_CYCLES));
    vib = 1'b0;
    $display("t_vib done");
  endtask : t_vib
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    t_start;
    t_rev;
    t_vib;
    report_and_stop;
  end
  initial
  begin
    #900000;
    fails++;
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
